// *** design/line_fault_pkg.sv ***
// Constants and types shared by the line fault relay decision logic.
package line_fault_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int PICKUP_MS = 50;
	localparam int PICKUP_TICKS = PICKUP_MS / TICK_MS;
	localparam int DELAY_W = 20;
	localparam int TICK_CNT_W = 17;
	localparam int VOLT_W = 14;
	localparam logic [DELAY_W-1:0] DELAY_OFF = 20'h00000;
	localparam logic [1:0] RESP_AUTO = 2'h0;
	localparam logic [1:0] RESP_MANUAL = 2'h1;
	localparam logic [1:0] RESP_REMOTE = 2'h2;
	typedef enum logic [1:0] {SEQ_UNKNOWN, SEQ_GOOD, SEQ_BAD} seq_t;
	typedef enum logic [1:0] {ST_OFF, ST_PICKUP, ST_HEALTHY, ST_TRIP} fault_state_t;
endpackage : line_fault_pkg

// *** design/line_fault_relay_logic.sv ***
// Decision logic driving the rotation and fault relays of a three-phase line monitor.
`timescale 1ns/1ps
module line_fault_relay_logic
	import line_fault_pkg::*;
#(
	// Clock cycles per time-base tick; a bench may shorten it to keep runs brief.
	parameter int TICK_LEN = TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] phase_present,
	input wire logic seq_correct,
	input wire logic neutral_fail,
	input wire logic asym_ok,
	input wire logic [VOLT_W-1:0] volt_ln_1,
	input wire logic [VOLT_W-1:0] volt_ln_2,
	input wire logic [VOLT_W-1:0] volt_ln_3,
	input wire logic [VOLT_W-1:0] volt_ll_12,
	input wire logic [VOLT_W-1:0] volt_ll_23,
	input wire logic [VOLT_W-1:0] volt_ll_31,
	input wire logic [VOLT_W-1:0] thr_low,
	input wire logic [VOLT_W-1:0] thr_high,
	input wire logic four_wire_mode,
	input wire logic [DELAY_W-1:0] dly_over,
	input wire logic [DELAY_W-1:0] dly_under,
	input wire logic [DELAY_W-1:0] dly_asym,
	input wire logic rot_on_fault_release,
	input wire logic [1:0] reset_response,
	input wire logic fault_ack,
	output logic rotation_relay,
	output logic fault_relay,
	output logic rotation_symbol,
	output logic fault_symbol,
	output logic [VOLT_W-1:0] disp_volt_1,
	output logic [VOLT_W-1:0] disp_volt_2,
	output logic [VOLT_W-1:0] disp_volt_3
);
	function automatic logic in_window(input logic [VOLT_W-1:0] v, input logic [VOLT_W-1:0] lo,
		input logic [VOLT_W-1:0] hi);
		in_window = (v > lo) && (v < hi);
	endfunction : in_window

	// Time base: one pulse per millisecond.
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic tick_r;
	wire tick_wrap = (tick_cnt_r == TICK_CNT_W'(TICK_LEN - 1));
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 17'h00001;
			tick_r <= tick_wrap;
		end
	end

	// Measurement selection follows the wiring mode.
	wire [VOLT_W-1:0] v1 = four_wire_mode ? volt_ln_1 : volt_ll_12;
	wire [VOLT_W-1:0] v2 = four_wire_mode ? volt_ln_2 : volt_ll_23;
	wire [VOLT_W-1:0] v3 = four_wire_mode ? volt_ln_3 : volt_ll_31;
	wire ok1 = in_window(v1, thr_low, thr_high);
	wire ok2 = in_window(v2, thr_low, thr_high);
	wire ok3 = in_window(v3, thr_low, thr_high);
	wire over_fault = (v1 >= thr_high) || (v2 >= thr_high) || (v3 >= thr_high);
	wire under_fault = !(ok1 && ok2 && ok3) && !over_fault;
	wire asym_fault = !asym_ok;
	wire all_present = &phase_present;
	wire none_present = ~|phase_present;
	wire phase_fail = !all_present || (four_wire_mode && neutral_fail);

	// Sequence latch: once the phase set has been partial, hold the last verdict.
	logic eval_lock_r;
	seq_t seq_r;
	wire may_eval = all_present && !eval_lock_r;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			eval_lock_r <= 1'b0;
			seq_r <= SEQ_UNKNOWN;
		end
		else
		begin
			if (none_present)
				eval_lock_r <= 1'b0;
			else if (!all_present)
				eval_lock_r <= 1'b1;
			if (may_eval)
				seq_r <= seq_correct ? SEQ_GOOD : SEQ_BAD;
			else if (none_present)
				seq_r <= SEQ_UNKNOWN;
		end
	end
	wire seq_good = (seq_r == SEQ_GOOD);

	// Tripping delays for each fault class.
	logic over_exp;
	logic under_exp;
	logic asym_exp;
	trip_delay_timer u_over (.clk(clk), .rstn(rstn), .tick(tick_r), .run(over_fault && !phase_fail),
		.limit(dly_over), .expired(over_exp));
	trip_delay_timer u_under (.clk(clk), .rstn(rstn), .tick(tick_r), .run(under_fault && !phase_fail),
		.limit(dly_under), .expired(under_exp));
	trip_delay_timer u_asym (.clk(clk), .rstn(rstn), .tick(tick_r), .run(asym_fault && !phase_fail),
		.limit(dly_asym), .expired(asym_exp));
	wire volt_fault = over_fault || under_fault || asym_fault;
	wire delayed_trip = over_exp || under_exp || asym_exp;
	wire delay_running = volt_fault && !delayed_trip && !phase_fail;
	wire healthy = !phase_fail && !volt_fault;
	wire may_restore = (reset_response == RESP_AUTO) || fault_ack;

	// Fault relay state machine.
	fault_state_t fst_r;
	fault_state_t fst_nxt;
	logic [6:0] pick_cnt_r;
	always_comb
	begin
		fst_nxt = fst_r;
		case (fst_r)
			ST_OFF:
				if (healthy && rotation_relay && !phase_fail)
					fst_nxt = ST_PICKUP;
			ST_PICKUP:
				if (phase_fail || volt_fault)
					fst_nxt = ST_OFF;
				else if (pick_cnt_r == 7'(PICKUP_TICKS))
					fst_nxt = ST_HEALTHY;
			ST_HEALTHY:
				if (phase_fail || delayed_trip)
					fst_nxt = ST_TRIP;
			ST_TRIP:
				if (healthy && may_restore)
					fst_nxt = ST_OFF;
			default:
				fst_nxt = ST_OFF;
		endcase
	end

	// Rotation relay optionally also drops on a tripped line, per configuration.
	wire rot_nxt = seq_good && !(rot_on_fault_release && fst_nxt == ST_TRIP);

	logic blink_r;
	logic [7:0] blink_cnt_r;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fst_r <= ST_OFF;
			pick_cnt_r <= '0;
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
			rotation_relay <= 1'b0;
			fault_relay <= 1'b0;
			rotation_symbol <= 1'b0;
			fault_symbol <= 1'b0;
			disp_volt_1 <= '0;
			disp_volt_2 <= '0;
			disp_volt_3 <= '0;
		end
		else
		begin
			fst_r <= fst_nxt;
			pick_cnt_r <= (fst_r != ST_PICKUP) ? 7'h00 : tick_r ? pick_cnt_r + 7'h01 : pick_cnt_r;
			if (tick_r)
				blink_cnt_r <= blink_cnt_r + 8'h01;
			if (tick_r && blink_cnt_r == 8'hF9)
				blink_r <= !blink_r;
			rotation_relay <= rot_nxt;
			fault_relay <= (fst_nxt == ST_HEALTHY);
			rotation_symbol <= rot_nxt;
			fault_symbol <= delay_running ? blink_r : (fst_nxt == ST_HEALTHY);
			disp_volt_1 <= v1;
			disp_volt_2 <= v2;
			disp_volt_3 <= v3;
		end
	end

	a_phase_drop: assert property (@(posedge clk) disable iff (!rstn)
		(phase_fail && fault_relay) |=> !fault_relay) else $error("fault relay held on phase loss");
	a_window_strict: assert property (@(posedge clk) disable iff (!rstn)
		(v1 == thr_low) |-> !ok1) else $error("threshold value counted as good");
	a_rot_follow: assert property (@(posedge clk) disable iff (!rstn)
		(seq_r == SEQ_BAD) |=> !rotation_relay) else $error("rotation relay on with bad sequence");
	a_lock_hold: assert property (@(posedge clk) disable iff (!rstn)
		(eval_lock_r && !none_present) |=> $stable(seq_r)) else $error("sequence re-evaluated while locked");
	a_unlock_all_off: assert property (@(posedge clk) disable iff (!rstn)
		none_present |=> !eval_lock_r) else $error("lock not cleared with all phases off");
	a_pickup_after: assert property (@(posedge clk) disable iff (!rstn)
		$rose(fault_relay) |-> $past(rotation_relay, 2)) else $error("fault relay before rotation relay");
	a_mode_select: assert property (@(posedge clk) disable iff (!rstn)
		!four_wire_mode |=> disp_volt_1 == $past(volt_ll_12)) else $error("wrong displayed voltage");
	a_delay_trip: assert property (@(posedge clk) disable iff (!rstn)
		(fault_relay && !phase_fail && !delayed_trip) |=> fault_relay) else $error("early trip");
endmodule : line_fault_relay_logic

// *** design/trip_delay_timer.sv ***
// Delay counter that runs on a millisecond tick and reports expiry.
`timescale 1ns/1ps
module trip_delay_timer
	import line_fault_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic run,
	input wire logic [DELAY_W-1:0] limit,
	output logic expired
);
	logic [DELAY_W-1:0] cnt_r;
	logic [DELAY_W-1:0] cnt_nxt;
	wire bypass = (limit == DELAY_OFF);
	wire at_limit = (cnt_r >= limit);

	// An off setting expires at once; otherwise count ticks while running.
	assign cnt_nxt = !run ? DELAY_OFF : (tick && !at_limit) ? cnt_r + 20'h00001 : cnt_r;
	assign expired = run && (bypass || at_limit);

	always_ff @(posedge clk)
	begin
		if (!rstn)
			cnt_r <= DELAY_OFF;
		else
			cnt_r <= cnt_nxt;
	end
endmodule : trip_delay_timer

// *** test/fe_model.sv ***
// Measurement front end model that turns test requests into synchronous flags and voltages.
`timescale 1ns/1ps
module fe_model
	import line_fault_pkg::*;
(
	input wire logic clk,
	input wire logic [2:0] want_on,
	input wire logic want_seq,
	input wire logic [VOLT_W-1:0] level,
	output logic [2:0] phase_present = 3'h0,
	output logic seq_correct = 1'b0,
	output logic asym_ok = 1'b0,
	output logic [VOLT_W-1:0] v_ln = 14'h0000,
	output logic [VOLT_W-1:0] v_ll = 14'h0000
);
	// Flags move only on the falling edge, so the logic never samples a half-settled flag.
	always @(negedge clk)
	begin
		phase_present <= want_on;
		seq_correct <= want_seq;
		asym_ok <= 1'b1;
		v_ln <= level;
		v_ll <= level + 14'h0001;
	end
endmodule : fe_model

// *** test/line_fault_relay_logic_test.sv ***
// Self-checking bench for the line fault relay decision logic.
`timescale 1ns/1ps
`define CHECK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t: got %h, expected %h", $time, a, b); end end
module line_fault_relay_logic_test;
	import line_fault_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] want_on = 3'h0;
	logic want_seq = 1'b0;
	logic four_wire_mode = 1'b1;
	logic [VOLT_W-1:0] level = 14'h0400;
	logic [VOLT_W-1:0] lo = 14'h0100;
	logic [DELAY_W-1:0] dly = 20'h00005;
	logic [2:0] phase_present;
	logic seq_correct, asym_ok, rot, flt, rot_sym, flt_sym;
	logic [VOLT_W-1:0] v_ln, v_ll, disp1;
	logic [15:0] notes[$];
	logic [15:0] n;
	int miscompares = 0;
	int n_checks = 0;
	event sample;
	always #5 clk = ~clk;
	fe_model fe (.clk(clk), .want_on(want_on), .want_seq(want_seq), .level(level),
		.phase_present(phase_present), .seq_correct(seq_correct), .asym_ok(asym_ok), .v_ln(v_ln), .v_ll(v_ll));
	line_fault_relay_logic #(.TICK_LEN(100)) dut (.clk(clk), .rstn(rstn), .phase_present(phase_present),
		.seq_correct(seq_correct),
		.neutral_fail(1'b0), .asym_ok(asym_ok), .volt_ln_1(v_ln), .volt_ln_2(v_ln), .volt_ln_3(v_ln),
		.volt_ll_12(v_ll), .volt_ll_23(v_ll), .volt_ll_31(v_ll), .thr_low(lo), .thr_high(14'h0800),
		.four_wire_mode(four_wire_mode), .dly_over(dly), .dly_under(dly), .dly_asym(dly),
		.rot_on_fault_release(1'b0), .reset_response(2'h0), .fault_ack(1'b0), .rotation_relay(rot),
		.fault_relay(flt), .rotation_symbol(rot_sym), .fault_symbol(flt_sym), .disp_volt_1(disp1),
		.disp_volt_2(), .disp_volt_3());
	function automatic logic [13:0] pick(input logic [1:0] sel);
		case (sel)
			2'h0: return {13'h0000, rot};
			2'h1: return {13'h0000, flt};
			2'h2: return disp1;
			default: return {13'h0000, rot_sym};
		endcase
	endfunction : pick
	// The watcher drains every note posted so far against the outputs of this moment.
	always @(sample)
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			`CHECK(pick(n[15:14]), n[13:0])
		end
	task automatic note(input logic [1:0] sel, input logic [13:0] val);
		notes.push_back({sel, val});
		->sample;
	endtask : note
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic summarize();
		$display("Checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// The bench tick is 100 cycles; two 50-tick pickups plus short delays fit well inside this span.
	initial
	begin
		#200_000;
		miscompares++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'h24249a8b));
		level = 14'h0101 + 14'($urandom % 1536);
		cyc(20);
		rstn = 1'b1;
		want_on = 3'h7;
		want_seq = 1'b1;
		cyc(4);
		note(2'h0, 14'h0001);
		note(2'h3, 14'h0001);
		note(2'h2, level);
		note(2'h1, 14'h0000);
		cyc(4_800);
		note(2'h1, 14'h0000);
		cyc(400);
		note(2'h1, 14'h0001);
		four_wire_mode = 1'b0;
		cyc(3);
		note(2'h2, level + 14'h0001);
		four_wire_mode = 1'b1;
		$display("pickup and display done");
		want_on = 3'h6;
		cyc(3);
		note(2'h1, 14'h0000);
		note(2'h0, 14'h0001);
		want_seq = 1'b0;
		want_on = 3'h7;
		cyc(4);
		note(2'h0, 14'h0001);
		want_on = 3'h0;
		cyc(4);
		want_on = 3'h7;
		cyc(4);
		note(2'h0, 14'h0000);
		note(2'h3, 14'h0000);
		want_seq = 1'b1;
		cyc(4);
		note(2'h0, 14'h0001);
		$display("phase loss and sequence lock done");
		cyc(5_400);
		note(2'h1, 14'h0001);
		dly = 20'h00002;
		level = 14'h0800;
		cyc(50);
		note(2'h1, 14'h0001);
		cyc(300);
		note(2'h1, 14'h0000);
		$display("overvoltage delay done");
		cyc(2);
		summarize();
	end
endmodule : line_fault_relay_logic_test
